// *** design/prr_pkg.sv ***
// package for the peripheral pin routing block
// assumes a 32-bit apb master on the same clock
package prr_pkg;
  localparam logic [31:0] PRR_ROUTE_OFFSET = 32'h0000_00E2;
  // offset is a word index: byte address is four times it
  localparam logic [31:0] PRR_ROUTE_ADDR = {PRR_ROUTE_OFFSET[29:0], 2'h0};
  localparam logic [31:0] PRR_PIN_ADDR = 32'h0000_00F0;
  localparam logic [7:0] PRR_ROUTE_RESET = 8'h00;
  localparam int PRR_TAO_HI = 7;
  localparam int PRR_TAO_LO = 6;
  localparam int PRR_CPA_BIT = 5;
  localparam int PRR_CPS_BIT = 4;
  localparam int PRR_CLK_BIT = 3;
  localparam int PRR_TWB_BIT = 2;
  localparam int PRR_URX_BIT = 1;
  localparam int PRR_UTX_BIT = 0;
  localparam logic [1:0] PRR_TAO_NONE = 2'h0;
  localparam logic [1:0] PRR_TAO_ONE = 2'h1;
  localparam logic [1:0] PRR_TAO_TWO = 2'h2;
  localparam logic [1:0] PRR_TAO_ALL = 2'h3;
  localparam int PRR_UTX_PIN = 4;
  localparam int PRR_URX_PIN = 5;
  localparam int PRR_CC0_PIN = 0;
  localparam int PRR_CC1_PIN = 1;
  localparam int PRR_CC2_PIN = 2;
  localparam int PRR_SDA_PIN = 2;
  localparam int PRR_SCL_PIN = 3;
  localparam int PRR_CMP_PIN = 6;
  localparam int PRR_CLK_PIN = 7;

  typedef struct packed {
    logic [1:0] timerArrayOutputSelect;
    logic comparatorAsyncOutEn;
    logic comparatorSyncOutEn;
    logic clockOutEn;
    logic twoWireBusEn;
    logic uartReceiveRouteEn;
    logic uartTransmitRouteEn;
  } prr_route_t;

  // peripheral-side signals toward the pins
  typedef struct packed {
    logic [2:0] captureCompareOut;
    logic comparatorAsync;
    logic comparatorSync;
    logic sdaOut;
    logic sclOut;
    logic uartTransmitLine;
  } prr_periph_t;

  // per-function pin request: value and enable, enable only for clock and two-wire
  typedef struct packed {
    logic [2:0] ccVal;
    logic [2:0] ccEn;
    logic cpaVal;
    logic cpaEn;
    logic cpsVal;
    logic cpsEn;
    logic clkEn;
    logic sdaOe;
    logic sclOe;
    logic twbEn;
    logic txVal;
    logic txEn;
  } prr_pinreq_t;
endpackage

// *** design/prr_route.sv ***
// port pin routing enables with apb register access
// assumes apb master on clk; pins synchronised here
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module prr_route
  import prr_pkg::*;
#(
  parameter int PINS = 8
)
(
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [31:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire prr_periph_t periph, // peripheral outputs
  input wire logic [PINS-1:0] pinIn, // raw pin levels
  output logic [PINS-1:0] pinOut, // pin output value
  output logic [PINS-1:0] pinOe, // pin output enable
  output logic uartReceiveLine, // receive to uart
  output logic sdaIn, // serial data to bus unit
  output logic sclIn, // serial clock to bus unit
  output logic clockOutActive // clock output enabled, half-rate clock image routed
);
  typedef struct packed {
    prr_route_t route;
    logic [31:0] rdata;
    logic ready;
    logic err;
    prr_pinreq_t req;
    logic rx;
    logic sda;
    logic scl;
    logic clkPhase;
    logic [PINS-1:0] pinOut;
    logic [PINS-1:0] pinOe;
  } prr_state_t;

  prr_state_t st_q;
  prr_state_t st_d;
  logic [PINS-1:0] pinSync;
  logic [PINS-1:0] outVal;
  logic [PINS-1:0] outEn;

  // pin plan needs eight pins, status read holds at most 32
  if (PINS < 8 || PINS > 32)
  begin : g_pins_bad
    $error("prr_route needs eight to thirty-two pins");
  end

  prr_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din(pinIn),
    .dout(pinSync)
  );

  function automatic logic [2:0] ccMask(input logic [1:0] sel);
    case (sel)
      PRR_TAO_NONE: ccMask = 3'h0;
      PRR_TAO_ONE: ccMask = 3'h1;
      PRR_TAO_TWO: ccMask = 3'h3;
      PRR_TAO_ALL: ccMask = 3'h7;
      default: ccMask = 3'h0;
    endcase
  endfunction

  function automatic logic addrHit(input logic [31:0] a,
                                   input logic [31:0] b);
    addrHit = (a == b);
  endfunction

  always_comb
  begin
    st_d = st_q;
    st_d.ready = 1'b0;
    st_d.err = 1'b0;
    if (psel && !penable)
    begin
      st_d.ready = 1'b1;
      st_d.err = !addrHit(paddr, PRR_ROUTE_ADDR)
                 && !addrHit(paddr, PRR_PIN_ADDR);
      st_d.rdata = 32'h0000_0000;
      if (!pwrite && addrHit(paddr, PRR_ROUTE_ADDR))
      begin
        st_d.rdata = {24'h00_0000, st_q.route};
      end
      else if (!pwrite && addrHit(paddr, PRR_PIN_ADDR))
      begin
        st_d.rdata = {{(32 - PINS){1'b0}}, pinSync};
      end
    end
    if (psel && penable && st_q.ready && pwrite
        && addrHit(paddr, PRR_ROUTE_ADDR))
    begin
      st_d.route = prr_route_t'(pwdata[7:0]);
    end
    st_d.req.ccEn = ccMask(st_q.route.timerArrayOutputSelect);
    st_d.req.ccVal = periph.captureCompareOut;
    st_d.req.cpaEn = st_q.route.comparatorAsyncOutEn;
    st_d.req.cpaVal = periph.comparatorAsync;
    st_d.req.cpsEn = st_q.route.comparatorSyncOutEn;
    st_d.req.cpsVal = periph.comparatorSync;
    st_d.req.clkEn = st_q.route.clockOutEn;
    st_d.req.twbEn = st_q.route.twoWireBusEn;
    st_d.req.sdaOe = st_q.route.twoWireBusEn && !periph.sdaOut;
    st_d.req.sclOe = st_q.route.twoWireBusEn && !periph.sclOut;
    st_d.sda = st_q.req.twbEn ? pinSync[PRR_SDA_PIN] : 1'b1;
    st_d.scl = st_q.req.twbEn ? pinSync[PRR_SCL_PIN] : 1'b1;
    st_d.req.txEn = st_q.route.uartTransmitRouteEn;
    st_d.req.txVal = periph.uartTransmitLine;
    st_d.rx = st_q.route.uartReceiveRouteEn
              ? pinSync[PRR_URX_PIN] : 1'b1;
    st_d.clkPhase = !st_q.clkPhase;
    st_d.pinOut = outVal;
    st_d.pinOe = outEn;
  end

  // fixed pin plan: cc on 0..2, two-wire on 2 and 3
  always_comb
  begin
    outVal = '0;
    outEn = '0;
    outVal[PRR_UTX_PIN] = st_q.req.txVal;
    outEn[PRR_UTX_PIN] = st_q.req.txEn;
    outEn[PRR_SDA_PIN] = st_q.req.sdaOe;
    outEn[PRR_SCL_PIN] = st_q.req.sclOe;
    outVal[PRR_CC0_PIN] = st_q.req.ccVal[0];
    outEn[PRR_CC0_PIN] = st_q.req.ccEn[0];
    outVal[PRR_CC1_PIN] = st_q.req.ccVal[1];
    outEn[PRR_CC1_PIN] = st_q.req.ccEn[1];
    // two-wire takes the third channel's pin
    if (!st_q.req.twbEn)
    begin
      outVal[PRR_CC2_PIN] = st_q.req.ccVal[2];
      outEn[PRR_CC2_PIN] = st_q.req.ccEn[2];
    end
    // sync comparator wins when both are on
    outVal[PRR_CMP_PIN] = st_q.req.cpsEn ? st_q.req.cpsVal
                                          : st_q.req.cpaVal;
    outEn[PRR_CMP_PIN] = st_q.req.cpsEn || st_q.req.cpaEn;
    outVal[PRR_CLK_PIN] = !st_q.clkPhase;
    outEn[PRR_CLK_PIN] = st_q.req.clkEn;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= '0;
      st_q.route <= PRR_ROUTE_RESET;
      st_q.rx <= 1'b1;
      st_q.sda <= 1'b1;
      st_q.scl <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign pinOut = st_q.pinOut;
  assign pinOe = st_q.pinOe;
  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.err;
  assign uartReceiveLine = st_q.rx;
  assign sdaIn = st_q.sda;
  assign sclIn = st_q.scl;
  assign clockOutActive = st_q.req.clkEn;

  // assertions share one clock and the reset
  default clocking cb_chk @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // apb setup and access phases
  sequence s_apb_setup;
    psel && !penable;
  endsequence

  sequence s_apb_access;
    psel && penable;
  endsequence

  // accepted write to the route register
  sequence s_route_write;
    psel && penable && pready && pwrite && paddr == PRR_ROUTE_ADDR;
  endsequence

  // route change reaches the pins two edges on
  // field value two routes two channels
  chk_cc_fanout: assert property (
    st_q.route.timerArrayOutputSelect == PRR_TAO_TWO
    |=> ##1 (pinOe[PRR_CC0_PIN] && pinOe[PRR_CC1_PIN]
             && pinOut[PRR_CC1_PIN]
                == $past(periph.captureCompareOut[1], 2)))
    else $error("two channels not routed");

  chk_cc_none: assert property (
    st_q.route.timerArrayOutputSelect == PRR_TAO_NONE
    |=> ##1 (!pinOe[PRR_CC0_PIN] && !pinOe[PRR_CC1_PIN]))
    else $error("channel routed while field is zero");

  // field value three routes the third channel while two-wire is off
  chk_cc_all: assert property (
    st_q.route.timerArrayOutputSelect == PRR_TAO_ALL
    && !st_q.route.twoWireBusEn
    |=> ##1 (pinOe[PRR_CC2_PIN]
             && pinOut[PRR_CC2_PIN]
                == $past(periph.captureCompareOut[2], 2)))
    else $error("third channel not routed");

  // comparator pin released when both off
  chk_cpa_off: assert property (
    (!st_q.route.comparatorAsyncOutEn && !st_q.route.comparatorSyncOutEn)
    |=> ##1 !pinOe[PRR_CMP_PIN])
    else $error("comparator pin driven while off");

  chk_cpa_value: assert property (
    st_q.route.comparatorAsyncOutEn && !st_q.route.comparatorSyncOutEn
    |=> ##1 (pinOe[PRR_CMP_PIN]
             && pinOut[PRR_CMP_PIN] == $past(periph.comparatorAsync, 2)))
    else $error("async comparator not routed");

  chk_cps_value: assert property (
    st_q.route.comparatorSyncOutEn
    |=> ##1 (pinOe[PRR_CMP_PIN]
             && pinOut[PRR_CMP_PIN] == $past(periph.comparatorSync, 2)))
    else $error("sync comparator value wrong");

  chk_clk_route: assert property (
    st_q.route.clockOutEn |=> clockOutActive ##1 pinOe[PRR_CLK_PIN])
    else $error("clock output not routed");

  chk_clk_off: assert property (
    !st_q.route.clockOutEn |=> !clockOutActive ##1 !pinOe[PRR_CLK_PIN])
    else $error("clock output routed while off");

  chk_clk_toggle: assert property (
    pinOe[PRR_CLK_PIN]
    |=> (pinOut[PRR_CLK_PIN] != $past(pinOut[PRR_CLK_PIN])))
    else $error("clock image stalled");

  // two-wire lines idle high when off
  chk_twb_off: assert property (
    !st_q.req.twbEn |=> (sdaIn && sclIn))
    else $error("two-wire input seen while off");

  chk_twb_lines: assert property (
    st_q.route.twoWireBusEn
    |=> ##1 (pinOe[PRR_SDA_PIN] == !$past(periph.sdaOut, 2)
             && pinOe[PRR_SCL_PIN] == !$past(periph.sclOut, 2)
             && !pinOut[PRR_SDA_PIN] && !pinOut[PRR_SCL_PIN]))
    else $error("two-wire lines not routed");

  chk_rx_off: assert property (
    !st_q.route.uartReceiveRouteEn |=> uartReceiveLine)
    else $error("receive line leaked");

  // receive follows pin five when on
  chk_rx_on: assert property (
    st_q.route.uartReceiveRouteEn
    |=> (uartReceiveLine == $past(pinSync[PRR_URX_PIN])))
    else $error("receive line not routed");

  chk_tx_pin: assert property (
    ##2 (pinOe[PRR_UTX_PIN] == $past(st_q.route.uartTransmitRouteEn, 2)))
    else $error("transmit pin enable wrong");

  chk_tx_value: assert property (
    st_q.route.uartTransmitRouteEn
    |=> ##1 (pinOut[PRR_UTX_PIN]
             == $past(periph.uartTransmitLine, 2)))
    else $error("transmit value wrong");

  chk_route_wr: assert property (
    s_route_write |=> (st_q.route == $past(pwdata[7:0])))
    else $error("route register not updated");

  chk_reset_clear: assert property (
    $rose(arst_n)
    |-> (st_q.route == PRR_ROUTE_RESET && pinOe == '0
         && uartReceiveLine && sdaIn && sclIn))
    else $error("routing enabled after reset");

  // access phase is answered at once
  chk_apb_answer: assert property (
    s_apb_setup ##1 s_apb_access |-> pready)
    else $error("access phase not answered");

  // unmapped address flags an error
  chk_bad_addr: assert property (
    s_apb_setup ##0 (paddr != PRR_ROUTE_ADDR && paddr != PRR_PIN_ADDR)
    |=> (pready && pslverr))
    else $error("unmapped address not flagged");
endmodule

// *** design/prr_sync.sv ***
// two-flop synchroniser for a bus of pin inputs
// assumes inputs are asynchronous to clk
`timescale 1ns/1ps
module prr_sync
  import prr_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, low
  input wire logic [WIDTH-1:0] din, // raw pins
  output logic [WIDTH-1:0] dout // synchronised
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } prr_sync_st_t;

  prr_sync_st_t st_q;
  prr_sync_st_t st_d;

  if (WIDTH < 1)
  begin : g_width_bad
    $error("prr_sync width must be positive");
  end

  always_comb
  begin
    st_d.meta = din;
    st_d.sync = st_q.meta;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.sync;
endmodule

// *** dv/prr_pins.sv ***
// pin partner: pull-up pins shared with outside drivers
// assumes open-drain style wired-and resolution
`timescale 1ns/1ps
module prr_pins
#(
  parameter int PINS = 8
)
(
  input wire logic [PINS-1:0] pinOut, // device value
  input wire logic [PINS-1:0] pinOe, // device drives
  input wire logic [PINS-1:0] extVal, // outside value
  input wire logic [PINS-1:0] extOe, // outside drives
  output logic [PINS-1:0] pinLvl // resolved level
);
  // released pins float to the pull-up level
  assign pinLvl = (pinOut | ~pinOe) & (extVal | ~extOe);
endmodule

// *** dv/prr_route_test.sv ***
// self-checking bench for the pin routing register
// assumes apb slave answers with pready, pins via prr_pins
`timescale 1ns/1ps
module prr_route_test;
  import prr_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, errv, sdaIn, sclIn, uartReceiveLine, clkAct;
  prr_periph_t periph = '{3'h5, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [7:0] extVal = 8'h00;
  logic [7:0] extOe = 8'h00;
  logic [7:0] pinLvl, pinOut, pinOe;
  logic prev;
  int err_total = 0;
  int checks = 0;
  always #5 clk = ~clk;
  prr_route dut (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph(periph), .pinIn(pinLvl),
    .pinOut(pinOut), .pinOe(pinOe), .uartReceiveLine(uartReceiveLine),
    .sdaIn(sdaIn), .sclIn(sclIn), .clockOutActive(clkAct));
  prr_pins pins (.pinOut(pinOut), .pinOe(pinOe), .extVal(extVal),
    .extOe(extOe), .pinLvl(pinLvl));
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    checks++;
    if (exp !== got)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] addr, dat);
    int n;
    logic ok;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= dat;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      ok = pready;
      rdv = prdata;
      errv = pslverr;
      n++;
    end
    while (ok !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (ok !== 1'b1)
    begin
      err_total++;
      print_verdict();
    end
  endtask
  // write route value, let the two pin stages settle
  task automatic setr(input logic [7:0] v);
    apb(1'b1, PRR_ROUTE_ADDR, {24'h0, v});
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic t_reset;
    apb(1'b0, PRR_ROUTE_ADDR, 32'h0);
    chk("route", 32'h0, rdv);
    chk("oe", 32'h0, pinOe);
  endtask
  task automatic t_timer;
    for (int v = 0; v < 4; v++)
    begin
      setr({v[1:0], 6'h0});
      chk("ccoe", (1 << v) - 1, pinOe[2:0]);
      chk("ccval", 5 & ((1 << v) - 1), pinOut[2:0] & pinOe[2:0]);
    end
  endtask
  task automatic t_misc;
    setr(8'h20);
    chk("cpa", 2'h3, {pinOe[6], pinOut[6]});
    setr(8'h10);
    chk("cps", 2'h2, {pinOe[6], pinOut[6]});
    setr(8'h08);
    chk("clk", 2'h3, {clkAct, pinOe[7]});
    prev = pinOut[7];
    @(negedge clk);
    chk("clktgl", {~prev}, pinOut[7]);
    setr(8'h00);
    chk("off", 3'h0, {clkAct, pinOe[7], pinOe[6]});
  endtask
  task automatic t_wire;
    setr(8'h04);
    chk("twoe", 2'h1, pinOe[3:2]);
    chk("twin", 2'h1, {sdaIn, sclIn});
    @(posedge clk);
    extOe <= 8'h28;
    setr(8'h07);
    chk("scl", 1'b0, sclIn);
    chk("rx", 1'b0, uartReceiveLine);
    chk("tx", 2'h2, {pinOe[4], pinOut[4]});
    apb(1'b0, PRR_PIN_ADDR, 32'h0);
    chk("pins", 32'hC3, rdv);
    setr(8'h01);
    chk("idle", 2'h3, {sclIn, uartReceiveLine});
    apb(1'b1, 32'h0000_00E4, 32'hFF);
    chk("bad", 1'b1, errv);
    apb(1'b0, PRR_ROUTE_ADDR, 32'h0);
    chk("keep", 32'h1, rdv);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_timer();
    t_misc();
    t_wire();
    print_verdict();
  end
endmodule
